/* File: src/mcc_pkg.sv */
// Constants, register map and field layout of the main clock controller.
// Assumes one 200 MHz clock and a plain register port with 8-bit data.
//
// Contract
// - Main source control bit 7 routes the system clock to its output pin.
// - In sleep the clock output stays quiet unless a peripheral uses the clock.
// - Source select: 0 fast osc, 1 slow osc, 3 external input, 2 reserved.
// - Ratio codes 0-5 divide by 2..64, codes 8-C by 6,10,12,24,48.
// - With prescaling off the peripheral clock equals the main clock.
// - The ratio field may be rewritten at run time without reset.
// - The freeze bit blocks writes to both main controls and itself, and to trim only while the fast osc is the active source.
// - At reset the freeze bit loads from the trim freeze fuse.
// - External status reads one once the external clock has started.
// - Stability bits read one only when stable and actually requested.
// - Switching bit is high until the new source is stable, then clears.
// - Keep-running bit holds its oscillator on in every mode.
// - A kept-running oscillator gives no output until requested.
// - Clock gate opens four oscillator cycles after request; no analog delay.
// - Six-bit fast trim field loads factory values chosen by the fuse.
// - Fuse freeze bit, read only, blocks both fast trim registers.
// - Four-bit temperature slope field loads factory values chosen by fuse.
// - Guarded writes need the key written first, within four instructions.
// - Unkeyed writes to guarded registers are taken but change nothing.
package mcc_pkg;
  localparam logic [7:0] OFF_SRC    = 8'h00;
  localparam logic [7:0] OFF_PRE    = 8'h01;
  localparam logic [7:0] OFF_FRZ    = 8'h02;
  localparam logic [7:0] OFF_STATE  = 8'h03;
  localparam logic [7:0] OFF_FCTRL  = 8'h10;
  localparam logic [7:0] OFF_FTRIM  = 8'h11;
  localparam logic [7:0] OFF_FTEMP  = 8'h12;
  localparam logic [7:0] OFF_SCTRL  = 8'h18;
  localparam logic [7:0] RST_SRC    = 8'h00;
  localparam logic [7:0] RST_PRE    = 8'h11;
  localparam int         BIT_SYSTEM_CLOCK_OUTPUT = 7;
  localparam int         BIT_EXT_SOURCE_STARTED   = 7;
  localparam int         BIT_SLOWS  = 5;
  localparam int         BIT_FASTS  = 4;
  localparam int         BIT_KEEP   = 1;
  localparam logic [1:0] SRC_FAST   = 2'h0;
  localparam logic [1:0] SRC_SLOW   = 2'h1;
  localparam logic [1:0] SRC_EXT    = 2'h3;
  localparam logic [2:0] GUARD_WIN  = 3'h4;
  localparam logic [2:0] GATE_CYC   = 3'h4;
  localparam logic [1:0] EXT_CYC    = 2'h2;
  typedef enum logic [1:0] {MCC_IDLE, MCC_WAIT} mcc_sw_t;
endpackage : mcc_pkg

/* File: src/mcc_main_clock_controller.sv */
// Main clock controller register block and clock-select logic.
// Oscillator clocks arrive as levels sampled on mclk; all are slow against it.
//
// Our own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none
module mcc_main_clock_controller
  import mcc_pkg::*;
(
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       resetn,
  // Register port.
  input  wire logic [7:0] regAddr,
  input  wire logic [7:0] regWdata,
  input  wire logic       regWrite,
  input  wire logic       regRead,
  output logic      [7:0] regRdata,
  // Change guard: one-cycle pulse when the key reaches the guard register.
  input  wire logic       ioRegisterKey,
  input  wire logic       instrDone,
  // Fuses.
  input  wire logic       fuseTrimFreeze,
  input  wire logic [5:0] fuseTrim,
  input  wire logic [3:0] fuseTempSlope,
  // System state.
  input  wire logic       sleeping,
  input  wire logic       standby,
  input  wire logic       perUsesClock,
  input  wire logic       fastReq,
  input  wire logic       slowReq,
  input  wire logic       extReq,
  input  wire logic       fastRaw,
  input  wire logic       slowRaw,
  input  wire logic       extRaw,
  // Clock outputs.
  output logic            mainClock,
  output logic            peripheralClock,
  output logic            systemClockOutput,
  output logic            fastRun,
  output logic            slowRun,
  output logic [1:0]      activeSource,
  output logic [5:0]      fastTrimOut,
  output logic [3:0]      fastTempOut
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] srcReg;
  logic [4:0] preReg;
  logic       freezeReg;
  logic       fuseFreezeReg;
  logic       fastKeepReg;
  logic       slowKeepReg;
  logic [5:0] trimReg;
  logic [3:0] tempReg;
  logic       loadedReg;
  logic [2:0] keyCntReg;
  logic [2:0] fastSync;
  logic [2:0] slowSync;
  logic [2:0] extSync;
  logic [2:0] fastGateCnt;
  logic [2:0] slowGateCnt;
  logic [1:0] extCnt;
  logic       extStartedReg;
  logic [1:0] activeReg;
  mcc_sw_t    swReg;
  logic [6:0] divCntReg;
  logic       perReg;
  logic [7:0] rdataReg;
  logic       keyOk;
  logic       wr;
  logic       fastOpen;
  logic       slowOpen;
  logic       fastUse;
  logic       slowUse;
  logic       sysClk;

  // Main clock edges, rising and falling both counted, per peripheral half period.
  // Reserved codes fall back to one edge, which passes the main clock undivided.
  function automatic logic [6:0] ratio_edges(input logic [3:0] code);
    case (code)
      4'h0: ratio_edges = 7'h02;
      4'h1: ratio_edges = 7'h04;
      4'h2: ratio_edges = 7'h08;
      4'h3: ratio_edges = 7'h10;
      4'h4: ratio_edges = 7'h20;
      4'h5: ratio_edges = 7'h40;
      4'h8: ratio_edges = 7'h06;
      4'h9: ratio_edges = 7'h0A;
      4'hA: ratio_edges = 7'h0C;
      4'hB: ratio_edges = 7'h18;
      4'hC: ratio_edges = 7'h30;
      default: ratio_edges = 7'h01;
    endcase
  endfunction : ratio_edges

  ////////////////////////////////////////////////////////////////////////////
  // Change guard window, counted in completed instructions.
  // A write closes the window unless a key pulse lands in the same cycle, so one key unlocks at most one register write.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      keyCntReg <= 3'h0;
    end else if (ioRegisterKey) begin
      keyCntReg <= GUARD_WIN;
    end else if (regWrite || (instrDone && keyCntReg != 3'h0)) begin
      keyCntReg <= regWrite ? 3'h0 : keyCntReg - 3'h1;
    end
  end
  assign keyOk = keyCntReg != 3'h0;
  assign wr    = regWrite && keyOk;

  // Fuse values are caught on the first clock after reset release.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      loadedReg <= 1'b0;
    end else begin
      loadedReg <= 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fuseFreezeReg <= 1'b0;
      freezeReg     <= 1'b0;
    end else if (!loadedReg) begin
      fuseFreezeReg <= fuseTrimFreeze;
      freezeReg     <= fuseTrimFreeze;
    end else if (wr && regAddr == OFF_FRZ && !freezeReg) begin
      freezeReg <= regWdata[0];
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      srcReg <= RST_SRC;
      preReg <= RST_PRE[4:0];
    end else if (wr && !freezeReg) begin
      if (regAddr == OFF_SRC) begin
        srcReg <= regWdata & 8'h83;
      end
      if (regAddr == OFF_PRE) begin
        preReg <= regWdata[4:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      trimReg <= 6'h00;
      tempReg <= 4'h0;
    end else if (!loadedReg) begin
      trimReg <= fuseTrim;
      tempReg <= fuseTempSlope;
    end else if (wr && !fuseFreezeReg && !(freezeReg && activeReg == SRC_FAST)) begin
      if (regAddr == OFF_FTRIM) begin
        trimReg <= regWdata[5:0];
      end
      if (regAddr == OFF_FTEMP) begin
        tempReg <= regWdata[3:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fastKeepReg <= 1'b0;
      slowKeepReg <= 1'b0;
    end else if (wr) begin
      if (regAddr == OFF_FCTRL) begin
        fastKeepReg <= regWdata[BIT_KEEP];
      end
      if (regAddr == OFF_SCTRL) begin
        slowKeepReg <= regWdata[BIT_KEEP];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator run and gate control. Sampling costs accuracy of the
  // divided clocks but keeps everything in one domain.
  assign fastUse = fastReq || srcReg[1:0] == SRC_FAST || activeReg == SRC_FAST;
  assign slowUse = slowReq || srcReg[1:0] == SRC_SLOW || activeReg == SRC_SLOW;
  assign fastRun = fastUse || fastKeepReg;
  assign slowRun = slowUse || slowKeepReg;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fastSync <= 3'h0;
      slowSync <= 3'h0;
      extSync  <= 3'h0;
    end else begin
      fastSync <= {fastSync[1:0], fastRaw};
      slowSync <= {slowSync[1:0], slowRaw};
      extSync  <= {extSync[1:0], extRaw};
    end
  end

  // Gate counters count sampled oscillator edges while the clock is wanted.
  // A kept-running oscillator still counts from zero when asked for, trading wake-up for a clean gate.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      fastGateCnt <= 3'h0;
      slowGateCnt <= 3'h0;
    end else begin
      if (!fastUse) begin
        fastGateCnt <= 3'h0;
      end else if (fastSync[2] && !fastSync[1] && !fastOpen) begin
        fastGateCnt <= fastGateCnt + 3'h1;
      end
      if (!slowUse) begin
        slowGateCnt <= 3'h0;
      end else if (slowSync[2] && !slowSync[1] && !slowOpen) begin
        slowGateCnt <= slowGateCnt + 3'h1;
      end
    end
  end
  assign fastOpen = fastGateCnt == GATE_CYC;
  assign slowOpen = slowGateCnt == GATE_CYC;

  // The external input needs two sampled edges before it counts as started.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      extCnt        <= 2'h0;
      extStartedReg <= 1'b0;
    end else if (!(extReq || srcReg[1:0] == SRC_EXT || activeReg == SRC_EXT)) begin
      extCnt        <= 2'h0;
      extStartedReg <= 1'b0;
    end else if (extSync[2] && !extSync[1] && !extStartedReg) begin
      extCnt        <= extCnt + 2'h1;
      extStartedReg <= (extCnt + 2'h1) == EXT_CYC;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source switching: the old source runs until the new one is stable.
  // A reserved code leaves the current source in charge rather than stopping the clock.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      activeReg <= SRC_FAST;
      swReg     <= MCC_IDLE;
    end else begin
      case (swReg)
        MCC_IDLE: begin
          if (srcReg[1:0] != activeReg && srcReg[1:0] != 2'h2) begin
            swReg <= MCC_WAIT;
          end
        end
        MCC_WAIT: begin
          if ((srcReg[1:0] == SRC_FAST && fastOpen) || (srcReg[1:0] == SRC_SLOW && slowOpen)
              || (srcReg[1:0] == SRC_EXT && extStartedReg)) begin
            activeReg <= srcReg[1:0];
            swReg     <= MCC_IDLE;
          end else if (srcReg[1:0] == activeReg || srcReg[1:0] == 2'h2) begin
            swReg <= MCC_IDLE;
          end
        end
        default: swReg <= MCC_IDLE;
      endcase
    end
  end

  always_comb begin
    case (activeReg)
      SRC_SLOW: sysClk = slowSync[2];
      SRC_EXT:  sysClk = extSync[2];
      default:  sysClk = fastSync[2];
    endcase
  end

  // Prescaler: the output toggles after a ratio's worth of main clock edges. A ratio
  // change applies to the count already running, so one odd half period may follow it.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      divCntReg <= 7'h00;
      perReg    <= 1'b0;
    end else if (sysClk != mainClock) begin
      if (divCntReg + 7'h01 >= ratio_edges(preReg[4:1])) begin
        divCntReg <= 7'h00;
        perReg    <= ~perReg;
      end else begin
        divCntReg <= divCntReg + 7'h01;
      end
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      mainClock         <= 1'b0;
      systemClockOutput <= 1'b0;
    end else begin
      mainClock         <= sysClk;
      // Standby counts as sleep for the pin; a peripheral still on the clock keeps it.
      systemClockOutput <= srcReg[BIT_SYSTEM_CLOCK_OUTPUT] && (!(sleeping || standby) || perUsesClock)
                           && sysClk;
    end
  end
  assign peripheralClock = preReg[0] ? perReg : mainClock;
  assign activeSource    = activeReg;
  assign fastTrimOut     = trimReg;
  assign fastTempOut     = tempReg;

  ////////////////////////////////////////////////////////////////////////////
  // Status is sampled at the read strobe, so a switch may end a cycle before it shows.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rdataReg <= 8'h00;
    end else if (regRead) begin
      case (regAddr)
        OFF_SRC:   rdataReg <= srcReg;
        OFF_PRE:   rdataReg <= {3'h0, preReg};
        OFF_FRZ:   rdataReg <= {7'h00, freezeReg};
        OFF_STATE: rdataReg <= {extStartedReg, 1'b0, slowOpen && slowUse, fastOpen && fastUse,
                                3'h0, swReg == MCC_WAIT};
        OFF_FCTRL: rdataReg <= {6'h00, fastKeepReg, 1'b0};
        OFF_FTRIM: rdataReg <= {2'h0, trimReg};
        OFF_FTEMP: rdataReg <= {fuseFreezeReg, 3'h0, tempReg};
        OFF_SCTRL: rdataReg <= {6'h00, slowKeepReg, 1'b0};
        default:   rdataReg <= 8'h00;
      endcase
    end else begin
      rdataReg <= 8'h00;
    end
  end
  assign regRdata = rdataReg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the guard, the freeze, the gates and the status read back.
  a_unkeyed_write: assert property (@(posedge mclk) disable iff (!resetn)
    regWrite && !keyOk && loadedReg |=> $stable(srcReg) && $stable(preReg))
    else $error("Unkeyed write changed a control.");
  a_freeze_holds: assert property (@(posedge mclk) disable iff (!resetn)
    freezeReg && loadedReg |=> freezeReg && $stable(srcReg))
    else $error("Frozen setting changed.");
  a_fuse_lock: assert property (@(posedge mclk) disable iff (!resetn)
    fuseFreezeReg && loadedReg |=> $stable(trimReg) && $stable(tempReg))
    else $error("Fuse frozen trim changed.");
  a_nodiv_pass: assert property (@(posedge mclk) disable iff (!resetn)
    !preReg[0] |-> peripheralClock == mainClock)
    else $error("Undivided clock mismatch.");
  a_out_sleep: assert property (@(posedge mclk) disable iff (!resetn)
    sleeping && !perUsesClock |=> !systemClockOutput)
    else $error("Clock out during sleep.");
  a_gate_idle: assert property (@(posedge mclk) disable iff (!resetn)
    !fastUse |=> fastGateCnt == 3'h0)
    else $error("Unused gate not closed.");
  a_switch_end: assert property (@(posedge mclk) disable iff (!resetn)
    swReg == MCC_WAIT && srcReg[1:0] == SRC_SLOW && slowOpen |=> activeReg == SRC_SLOW && swReg == MCC_IDLE)
    else $error("Switch did not finish on a stable source.");
  a_keep_run: assert property (@(posedge mclk) disable iff (!resetn)
    wr && regAddr == OFF_FCTRL |=> fastKeepReg == $past(regWdata[BIT_KEEP]))
    else $error("Keep-running bit not taken.");
  a_src_legal: assert property (@(posedge mclk) disable iff (!resetn)
    activeReg != 2'h2)
    else $error("Reserved source active.");
  a_gate_count: assert property (@(posedge mclk) disable iff (!resetn)
    fastUse && fastGateCnt == 3'h3 && fastSync[2] && !fastSync[1] |=> fastOpen)
    else $error("Fast gate missed its fourth edge.");
  a_ext_idle: assert property (@(posedge mclk) disable iff (!resetn)
    !extReq && srcReg[1:0] != SRC_EXT && activeReg != SRC_EXT |=> !extStartedReg)
    else $error("External status set without a request.");
  a_key_close: assert property (@(posedge mclk) disable iff (!resetn)
    regWrite && !ioRegisterKey |=> !keyOk)
    else $error("Guard window open after a write.");
  a_freeze_trim: assert property (@(posedge mclk) disable iff (!resetn)
    freezeReg && activeReg == SRC_FAST && loadedReg |=> $stable(trimReg) && $stable(tempReg))
    else $error("Frozen trim changed.");
  a_slow_status: assert property (@(posedge mclk) disable iff (!resetn)
    regRead && regAddr == OFF_STATE && !slowUse |=> !regRdata[BIT_SLOWS])
    else $error("Unused slow oscillator reported stable.");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!resetn)
    regRead && regAddr == 8'h05 |=> regRdata == 8'h00)
    else $error("Reserved offset read nonzero.");
  a_pre_unused: assert property (@(posedge mclk) disable iff (!resetn)
    regRead && regAddr == OFF_PRE |=> regRdata[7:5] == 3'h0)
    else $error("Unused prescale bits read nonzero.");
  c_switch: cover property (@(posedge mclk) disable iff (!resetn)
    swReg == MCC_WAIT ##1 swReg == MCC_IDLE);
  c_freeze: cover property (@(posedge mclk) disable iff (!resetn) $rose(freezeReg));
  c_system_clock_output: cover property (@(posedge mclk) disable iff (!resetn) $rose(systemClockOutput));
  c_ext_start: cover property (@(posedge mclk) disable iff (!resetn) $rose(extStartedReg));
  c_divided: cover property (@(posedge mclk) disable iff (!resetn) preReg[0] && $rose(perReg));
endmodule : mcc_main_clock_controller
`default_nettype wire

/* File: verif/mcc_main_clock_controller_bench.sv */
// Self-checking bench for the main clock controller register block.
// Drives every port itself; oscillators are slow square waves made from mclk.
`timescale 1ns/10ps
`default_nettype none
module mcc_main_clock_controller_bench;
  import mcc_pkg::*;
  logic       mclk = 0, resetn = 0, regWrite = 0, regRead = 0, ioRegisterKey = 0;
  logic       instrDone = 0, fuseTrimFreeze = 0, sleeping = 0, standby = 0;
  logic       perUsesClock = 0, fastReq = 0, slowReq = 0, extReq = 0;
  logic       fastRaw = 0, slowRaw = 0, extRaw = 0, pm = 0, pp = 0, po = 0;
  logic [7:0] regAddr = 8'h00, regWdata = 8'h00, regRdata, rdVal;
  logic [5:0] fuseTrim = 6'h2A, fastTrimOut;
  logic [3:0] fuseTempSlope = 4'h9, fastTempOut;
  logic       mainClock, peripheralClock, systemClockOutput, fastRun, slowRun;
  logic [1:0] activeSource;
  int         failures = 0, numChecks = 0, tick = 0, nMain = 0, nPer = 0, nOut = 0;
  int         dMain, dPer, dOut;
  int         divs [16] = '{2, 4, 8, 16, 32, 64, 0, 0, 6, 10, 12, 24, 48, 0, 0, 0};
  logic [1:0] srcs [3] = '{SRC_SLOW, SRC_EXT, SRC_FAST};
  int         stBit [3] = '{BIT_SLOWS, BIT_EXT_SOURCE_STARTED, BIT_FASTS};

  mcc_main_clock_controller u_dut (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .ioRegisterKey(ioRegisterKey), .instrDone(instrDone), .fuseTrimFreeze(fuseTrimFreeze),
    .fuseTrim(fuseTrim), .fuseTempSlope(fuseTempSlope), .sleeping(sleeping),
    .standby(standby), .perUsesClock(perUsesClock), .fastReq(fastReq), .slowReq(slowReq),
    .extReq(extReq), .fastRaw(fastRaw), .slowRaw(slowRaw), .extRaw(extRaw),
    .mainClock(mainClock), .peripheralClock(peripheralClock),
    .systemClockOutput(systemClockOutput), .fastRun(fastRun), .slowRun(slowRun),
    .activeSource(activeSource), .fastTrimOut(fastTrimOut), .fastTempOut(fastTempOut));

  ////////////////////////////////////////////////////////////////////////////////////////
  always #2.5 mclk = ~mclk;

  // Oscillators run far slower than mclk, as the synchronisers need.
  always @(posedge mclk) begin
    tick    <= tick + 1;
    fastRaw <= tick[2];
    slowRaw <= tick[4];
    extRaw  <= tick[3];
    pm      <= mainClock;
    pp      <= peripheralClock;
    po      <= systemClockOutput;
    if (mainClock === 1'b1 && pm === 1'b0) nMain <= nMain + 1;
    if (peripheralClock === 1'b1 && pp === 1'b0) nPer <= nPer + 1;
    if (systemClockOutput === 1'b1 && po === 1'b0) nOut <= nOut + 1;
  end

  ////////////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: value %h, wanted %h", $time, got, exp);
    end
  endtask : chk8

  task automatic chk1(input logic got, input logic exp);
    numChecks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: flag %b, wanted %b", $time, got, exp);
    end
  endtask : chk1

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input bit key);
    if (key) begin
      @(posedge mclk);
      ioRegisterKey <= 1'b1;
    end
    @(posedge mclk);
    ioRegisterKey <= 1'b0;
    regWrite      <= 1'b1;
    regAddr       <= a;
    regWdata      <= d;
    @(posedge mclk);
    regWrite      <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge mclk);
    regRead <= 1'b0;
    #1 d = regRdata;
  endtask : rd

  task automatic chkReg(input logic [7:0] a, input logic [7:0] exp);
    rd(a, rdVal);
    chk8(rdVal, exp);
  endtask : chkReg

  // Counts clock rises over a window; deltas avoid clearing shared counters.
  task automatic win(input int n);
    int m0, p0, o0;
    m0 = nMain;
    p0 = nPer;
    o0 = nOut;
    repeat (n) @(posedge mclk);
    dMain = nMain - m0;
    dPer  = nPer - p0;
    dOut  = nOut - o0;
  endtask : win

  task automatic doReset();
    @(posedge mclk);
    resetn <= 1'b0;
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
  endtask : doReset

  ////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    #400000;
    failures++;
    report_and_stop();
  end

  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    repeat (2) @(posedge mclk);
    chkReg(OFF_SRC, 8'h00);
    chkReg(OFF_PRE, RST_PRE);
    chkReg(OFF_FRZ, 8'h00);
    chkReg(OFF_FCTRL, 8'h00);
    chkReg(OFF_SCTRL, 8'h00);
    chkReg(OFF_FTRIM, 8'h2A);
    chkReg(OFF_FTEMP, 8'h09);
    chkReg(8'h05, 8'h00);
    wr(OFF_PRE, 8'h07, 0);
    chkReg(OFF_PRE, RST_PRE);
    @(posedge mclk);
    ioRegisterKey <= 1'b1;
    @(posedge mclk);
    ioRegisterKey <= 1'b0;
    repeat (4) begin
      instrDone <= 1'b1;
      @(posedge mclk);
    end
    instrDone <= 1'b0;
    wr(OFF_PRE, 8'h07, 0);
    chkReg(OFF_PRE, RST_PRE);
    wr(OFF_PRE, 8'hE0, 1);
    chkReg(OFF_PRE, 8'h00);
    repeat (32) begin
      @(negedge mclk);
      chk1(peripheralClock, mainClock);
    end
    for (int c = 0; c < 16; c++) begin
      if (divs[c] != 0) begin
        wr(OFF_PRE, {3'b000, 4'(c), 1'b1}, 1);
        chkReg(OFF_PRE, {3'b000, 4'(c), 1'b1});
        win(2048);
        chk1(dMain - dPer * divs[c] <= divs[c] && dPer * divs[c] - dMain <= divs[c], 1);
      end
    end
    wr(OFF_PRE, 8'h00, 1);
    for (int s = 0; s < 3; s++) begin
      extReq <= (s == 1);
      wr(OFF_SRC, {6'h00, srcs[s]}, 1);
      rd(OFF_STATE, rdVal);
      chk1(rdVal[0], 1'b1);
      for (int i = 0; i < 600 && activeSource !== srcs[s]; i++) @(posedge mclk);
      chk8({6'h00, activeSource}, {6'h00, srcs[s]});
      rd(OFF_STATE, rdVal);
      chk1(rdVal[0], 1'b0);
      chk1(rdVal[stBit[s]], 1'b1);
    end
    extReq <= 1'b0;
    wr(OFF_SRC, 8'h02, 1);
    repeat (40) @(posedge mclk);
    chk8({6'h00, activeSource}, {6'h00, SRC_FAST});
    wr(OFF_SRC, 8'h80, 1);
    win(256);
    chk1(dOut > 0, 1'b1);
    sleeping <= 1'b1;
    repeat (4) @(posedge mclk);
    win(256);
    chk1(dOut == 0, 1'b1);
    perUsesClock <= 1'b1;
    repeat (4) @(posedge mclk);
    win(256);
    chk1(dOut > 0, 1'b1);
    sleeping     <= 1'b0;
    perUsesClock <= 1'b0;
    wr(OFF_SRC, 8'h00, 1);
    repeat (4) @(posedge mclk);
    win(256);
    chk1(dOut == 0, 1'b1);
    wr(OFF_SCTRL, 8'hFF, 1);
    chkReg(OFF_SCTRL, 8'h02);
    wr(OFF_FCTRL, 8'h02, 1);
    standby  <= 1'b1;
    sleeping <= 1'b1;
    repeat (8) @(posedge mclk);
    chk1(slowRun, 1'b1);
    chk1(fastRun, 1'b1);
    rd(OFF_STATE, rdVal);
    chk1(rdVal[BIT_SLOWS], 1'b0);
    standby  <= 1'b0;
    sleeping <= 1'b0;
    slowReq  <= 1'b1;
    fastReq  <= 1'b1;
    rd(OFF_STATE, rdVal);
    chk1(rdVal[BIT_SLOWS], 1'b0);
    repeat (200) @(posedge mclk);
    rd(OFF_STATE, rdVal);
    chk1(rdVal[BIT_SLOWS], 1'b1);
    slowReq <= 1'b0;
    fastReq <= 1'b0;
    wr(OFF_FTRIM, 8'hD5, 1);
    chkReg(OFF_FTRIM, 8'h15);
    chk8({2'b00, fastTrimOut}, 8'h15);
    wr(OFF_FTEMP, 8'h8A, 1);
    chkReg(OFF_FTEMP, 8'h0A);
    chk8({4'h0, fastTempOut}, 8'h0A);
    wr(OFF_FRZ, 8'h01, 1);
    wr(OFF_PRE, 8'h03, 1);
    chkReg(OFF_PRE, 8'h00);
    wr(OFF_SRC, 8'h81, 1);
    chkReg(OFF_SRC, 8'h00);
    wr(OFF_FTRIM, 8'h01, 1);
    chkReg(OFF_FTRIM, 8'h15);
    fuseTrimFreeze <= 1'b1;
    fuseTrim       <= 6'h0C;
    doReset();
    chkReg(OFF_FRZ, 8'h01);
    chkReg(OFF_FTEMP, 8'h89);
    wr(OFF_FTRIM, 8'h3F, 1);
    chkReg(OFF_FTRIM, 8'h0C);
    report_and_stop();
  end
endmodule : mcc_main_clock_controller_bench
`default_nettype wire
